/* src/smbr_pkg.sv */
/*
 * Shared constants and types of the SMBus slave read engine.
 * Assumes an eight-bit register address space and an open-drain data line.
 */
package smbr_pkg;

   // Command code that announces a block-read process call.
   localparam logic [7:0] CMD_BLOCK_READ = 8'hf1;
   // Highest register address; the pointer saturates here.
   localparam logic [7:0] PTR_TOP = 8'hff;
   // Pointer value after reset.
   localparam logic [7:0] PTR_RESET = 8'h00;
   // Block length held after reset, until a master sends one.
   localparam logic [7:0] LEN_RESET = 8'h01;
   // Value returned for addresses outside the implemented space.
   localparam logic [7:0] DATA_OUTSIDE = 8'h00;
   // Default number of implemented registers, from address zero upward.
   localparam int IMPL_DEPTH_DEF = 192;

   // Bit positions within a byte: first, last, and the one after a START.
   localparam logic [2:0] BIT_FIRST = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h0;
   localparam logic [2:0] BIT_AFTER_START = 3'h6;

   // Position of a written byte after the address byte.
   localparam logic [2:0] IDX_CMD = 3'h0;
   localparam logic [2:0] IDX_WCOUNT = 3'h1;
   localparam logic [2:0] IDX_START = 3'h2;
   localparam logic [2:0] IDX_LEN = 3'h3;
   localparam logic [2:0] IDX_EXTRA = 3'h4;

   // Link state, advanced on each rising edge of the bus clock.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } smbr_state_t;

endpackage

/* src/smbr_mem_if.sv */
/*
 * Carrier between the read engine and its register memory.
 * Assumes every signal belongs to the system clock domain.
 */
`timescale 1ns/100ps

interface smbr_mem_if;
   logic ce;             // Clock enable of the system domain.
   logic [7:0] rd_addr;  // Address read every enabled cycle.
   logic [7:0] rd_data;  // Registered read data, one cycle behind the address.
   logic wr_en;          // Write strobe from the user side.
   logic [7:0] wr_addr;  // Write address.
   logic [7:0] wr_data;  // Write data.

   // The engine drives address and writes, the memory returns data.
   modport ctl (output ce, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
   modport mem (input ce, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

/* src/smbr_regmem.sv */
/*
 * Register memory of the monitor, read through a registered output.
 * Assumes one system clock, an asynchronous active-high reset, and a
 * user side that loads the register values through the write port.
 */
`timescale 1ns/100ps

module smbr_regmem #(
   parameter int DEPTH = smbr_pkg::IMPL_DEPTH_DEF
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   smbr_mem_if.mem bus
);

   // Storage; contents are not reset, as in any register array.
   logic [7:0] mem_q [0:DEPTH-1];
   // Registered read data and its next value.
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;

   // Reads outside the implemented space return zero.
   always_comb begin
      rd_data_next = rd_data_reg;
      if (bus.ce) begin
         if (int'(bus.rd_addr) < DEPTH) begin
            rd_data_next = mem_q[bus.rd_addr];
         end else begin
            rd_data_next = smbr_pkg::DATA_OUTSIDE;
         end
      end
   end

   // Read data register.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_data_reg <= 8'h00;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // Writes beyond the implemented space are dropped.
   always_ff @(posedge clk_i) begin
      if (bus.ce && bus.wr_en && (int'(bus.wr_addr) < DEPTH)) begin
         mem_q[bus.wr_addr] <= bus.wr_data;
      end
   end

   assign bus.rd_data = rd_data_reg;

   // Unimplemented addresses read as zero.
   chk_outside_zero: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (bus.ce && int'(bus.rd_addr) >= DEPTH) |=> (rd_data_reg == 8'h00))
      else $error("Read outside the register space did not return zero.");

endmodule

/* src/smbr_read_engine.sv */
/*
 * SMBus slave read engine: byte read, word read, block-read process call
 * and its split two-transaction form.
 * Assumes the master makes the bus clock, which drives the link domain;
 * the register memory lives in the system clock domain. The data line is
 * open drain: the module only pulls it low while its enable is high.
 */
`timescale 1ns/100ps

// Contract
// - Byte read: address, register, restart, one byte.
// - Word read returns two consecutive bytes.
// - Low byte first, then high byte.
// - Command F1h after address requests block read.
// - Start address and length acknowledged and stored.
// - Restart with read address acknowledged.
// - Count byte first, then data in order.
// - Unimplemented addresses read as zero.
// - Pointer never wraps past top address.
// - Keep sending while master acknowledges.
// - Release data line after master NACK.
// - Split form: parameters kept across STOP.
// - Split second part: F1h then read.
// - Split count equals earlier requested length.
// - Acknowledge own write address every protocol.
// - Pointer ends just past last byte read.
module smbr_read_engine #(
   parameter int IMPL_DEPTH = smbr_pkg::IMPL_DEPTH_DEF
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic scl_clk_i,
   input wire logic sda_i,
   input wire logic [6:0] slv_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_waddr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic sda_o,
   output logic sda_oe_o
);

   // Link domain state, clocked on the rising bus clock edge.
   smbr_pkg::smbr_state_t state_reg, state_next;
   logic [2:0] bit_reg, bit_next;       // Bit being moved in this byte.
   logic [7:0] shift_reg, shift_next;   // Receive and transmit shifter.
   logic [2:0] idx_reg, idx_next;       // Position of a written byte.
   logic rw_reg, rw_next;               // Direction of the addressed transfer.
   logic blk_reg, blk_next;             // Next read starts with a count byte.
   logic [7:0] len_reg, len_next;       // Requested block length.
   logic [7:0] ptr_reg, ptr_next;       // Register pointer.
   logic req_reg, req_next;             // Fetch request toggle.
   logic start_ack_reg, start_ack_next; // Last START seen.
   logic [7:0] fetch_reg, fetch_next;   // Prefetched byte at the pointer.
   logic ack_seen_reg, ack_seen_next;   // Last fetch answer taken.
   logic load_tx;                       // A byte is loaded for sending.
   logic [7:0] rx_byte;                 // Byte completed at this edge.

   // Synchronisers into the link domain.
   logic ce_s1, ce_s2;
   logic [6:0] addr_s1, addr_s2;
   logic ack_s1, ack_s2;

   // START detector, clocked by the falling data line.
   logic start_tog_reg, start_tog_next;

   // Falling-edge output stage.
   logic sda_oe_reg, sda_oe_next;
   logic sda_o_reg;

   // System domain fetch side.
   logic req_s1, req_s2;
   logic req_seen_reg, req_seen_next;
   logic pend_reg, pend_next;
   logic [7:0] hold_reg, hold_next;
   logic ack_tog_reg, ack_tog_next;

   smbr_mem_if mem_bus ();

   // The pointer is stable for many bus clocks around each request, so it
   // travels as bundled data with the request toggle.
   assign mem_bus.ce = ce_i;
   assign mem_bus.rd_addr = ptr_reg;
   assign mem_bus.wr_en = reg_wr_i;
   assign mem_bus.wr_addr = reg_waddr_i;
   assign mem_bus.wr_data = reg_wdata_i;

   smbr_regmem #(
      .DEPTH(IMPL_DEPTH)
   ) smbr_regmem_inst (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .bus(mem_bus)
   );

   // Request toggle into the system domain.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end else begin
         req_s1 <= req_reg;
         req_s2 <= req_s1;
      end
   end

   // A new request reads the memory; the answer follows a cycle later.
   always_comb begin
      req_seen_next = req_seen_reg;
      pend_next = 1'b0;
      hold_next = hold_reg;
      ack_tog_next = ack_tog_reg;
      if (req_s2 != req_seen_reg) begin
         req_seen_next = req_s2;
         pend_next = 1'b1;
      end
      if (pend_reg) begin
         hold_next = mem_bus.rd_data;
         ack_tog_next = ~ack_tog_reg;
      end
   end

   // System domain fetch registers, frozen while the enable is low.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_seen_reg <= 1'b0;
         pend_reg <= 1'b0;
         hold_reg <= 8'h00;
         ack_tog_reg <= 1'b0;
      end else if (ce_i) begin
         req_seen_reg <= req_seen_next;
         pend_reg <= pend_next;
         hold_reg <= hold_next;
         ack_tog_reg <= ack_tog_next;
      end
   end

   // START: the data line falls while the bus clock is high.
   always_comb begin
      start_tog_next = start_tog_reg;
      if (scl_clk_i) begin
         start_tog_next = ~start_tog_reg;
      end
   end

   // The toggle settles long before the next rising bus clock edge.
   always_ff @(negedge sda_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         start_tog_reg <= 1'b0;
      end else begin
         start_tog_reg <= start_tog_next;
      end
   end

   // Enable, slave address and fetch answer into the link domain.
   always_ff @(posedge scl_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ce_s1 <= 1'b0;
         ce_s2 <= 1'b0;
         addr_s1 <= 7'h00;
         addr_s2 <= 7'h00;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ce_s1 <= ce_i;
         ce_s2 <= ce_s1;
         addr_s1 <= slv_addr_i;
         addr_s2 <= addr_s1;
         ack_s1 <= ack_tog_reg;
         ack_s2 <= ack_s1;
      end
   end

   // Bit-level protocol: sample the data line and choose the next bit.
   always_comb begin
      state_next = state_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      idx_next = idx_reg;
      rw_next = rw_reg;
      blk_next = blk_reg;
      len_next = len_reg;
      ptr_next = ptr_reg;
      req_next = req_reg;
      start_ack_next = start_ack_reg;
      fetch_next = fetch_reg;
      ack_seen_next = ack_seen_reg;
      load_tx = 1'b0;
      rx_byte = {shift_reg[6:0], sda_i};
      // Take a fresh answer from the system domain.
      if (ack_s2 != ack_seen_reg) begin
         fetch_next = hold_reg;
         ack_seen_next = ack_s2;
      end
      if (start_tog_reg != start_ack_reg) begin
         // A START or restart: this edge carries the first address bit.
         // The fetch is renewed so that register changes are seen.
         start_ack_next = start_tog_reg;
         state_next = smbr_pkg::ST_ADDR;
         shift_next = {7'h00, sda_i};
         bit_next = smbr_pkg::BIT_AFTER_START;
         req_next = ~req_reg;
      end else begin
         case (state_reg)
            smbr_pkg::ST_ADDR: begin
               shift_next = rx_byte;
               if (bit_reg == smbr_pkg::BIT_LAST) begin
                  if (rx_byte[7:1] == addr_s2) begin
                     rw_next = rx_byte[0];
                     idx_next = smbr_pkg::IDX_CMD;
                     state_next = smbr_pkg::ST_ADDR_ACK;
                  end else begin
                     state_next = smbr_pkg::ST_IDLE;
                  end
               end else begin
                  bit_next = bit_reg - 3'h1;
               end
            end
            smbr_pkg::ST_ADDR_ACK: begin
               if (rw_reg) begin
                  load_tx = 1'b1;
               end else begin
                  state_next = smbr_pkg::ST_RX;
                  bit_next = smbr_pkg::BIT_FIRST;
               end
            end
            smbr_pkg::ST_RX: begin
               shift_next = rx_byte;
               if (bit_reg == smbr_pkg::BIT_LAST) begin
                  state_next = smbr_pkg::ST_RX_ACK;
                  if (idx_reg != smbr_pkg::IDX_EXTRA) begin
                     idx_next = idx_reg + 3'h1;
                  end
                  case (idx_reg)
                     smbr_pkg::IDX_CMD: begin
                        blk_next = (rx_byte == smbr_pkg::CMD_BLOCK_READ);
                        if (rx_byte != smbr_pkg::CMD_BLOCK_READ) begin
                           ptr_next = rx_byte;
                           req_next = ~req_reg;
                        end
                     end
                     smbr_pkg::IDX_START: begin
                        if (blk_reg) begin
                           ptr_next = rx_byte;
                           req_next = ~req_reg;
                        end
                     end
                     smbr_pkg::IDX_LEN: begin
                        if (blk_reg) begin
                           len_next = rx_byte;
                        end
                     end
                     default: begin
                        // Write count and further data are accepted and dropped.
                        len_next = len_reg;
                     end
                  endcase
               end else begin
                  bit_next = bit_reg - 3'h1;
               end
            end
            smbr_pkg::ST_RX_ACK: begin
               state_next = smbr_pkg::ST_RX;
               bit_next = smbr_pkg::BIT_FIRST;
            end
            smbr_pkg::ST_TX: begin
               shift_next = {shift_reg[6:0], 1'b0};
               if (bit_reg == smbr_pkg::BIT_LAST) begin
                  state_next = smbr_pkg::ST_TX_ACK;
               end else begin
                  bit_next = bit_reg - 3'h1;
               end
            end
            smbr_pkg::ST_TX_ACK: begin
               if (!sda_i) begin
                  load_tx = 1'b1;
               end else begin
                  state_next = smbr_pkg::ST_IDLE;
               end
            end
            default: begin
               state_next = smbr_pkg::ST_IDLE;
            end
         endcase
      end
      // Load the next byte to send; a data byte also prefetches the one after it.
      if (load_tx) begin
         state_next = smbr_pkg::ST_TX;
         bit_next = smbr_pkg::BIT_FIRST;
         if (blk_reg) begin
            shift_next = len_reg;
            blk_next = 1'b0;
         end else begin
            shift_next = fetch_reg;
            req_next = ~req_reg;
            if (ptr_reg != smbr_pkg::PTR_TOP) begin
               ptr_next = ptr_reg + 8'h01;
            end
         end
      end
   end

   // Link domain registers, frozen while the enable is low.
   always_ff @(posedge scl_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= smbr_pkg::ST_IDLE;
         bit_reg <= smbr_pkg::BIT_FIRST;
         shift_reg <= 8'h00;
         idx_reg <= smbr_pkg::IDX_CMD;
         rw_reg <= 1'b0;
         blk_reg <= 1'b0;
         len_reg <= smbr_pkg::LEN_RESET;
         ptr_reg <= smbr_pkg::PTR_RESET;
         req_reg <= 1'b0;
         start_ack_reg <= 1'b0;
         fetch_reg <= 8'h00;
         ack_seen_reg <= 1'b0;
      end else if (ce_s2) begin
         state_reg <= state_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         idx_reg <= idx_next;
         rw_reg <= rw_next;
         blk_reg <= blk_next;
         len_reg <= len_next;
         ptr_reg <= ptr_next;
         req_reg <= req_next;
         start_ack_reg <= start_ack_next;
         fetch_reg <= fetch_next;
         ack_seen_reg <= ack_seen_next;
      end
   end

   // Pull the line low for acknowledges and zero data bits; otherwise let go.
   always_comb begin
      sda_oe_next = 1'b0;
      if ((state_reg == smbr_pkg::ST_ADDR_ACK) || (state_reg == smbr_pkg::ST_RX_ACK)) begin
         sda_oe_next = 1'b1;
      end else if (state_reg == smbr_pkg::ST_TX) begin
         sda_oe_next = !shift_reg[7];
      end
   end

   // Output stage changes only while the bus clock is low.
   always_ff @(negedge scl_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sda_oe_reg <= 1'b0;
         sda_o_reg <= 1'b0;
      end else if (ce_s2) begin
         sda_oe_reg <= sda_oe_next;
         sda_o_reg <= 1'b0;
      end
   end

   assign sda_oe_o = sda_oe_reg;
   assign sda_o = sda_o_reg;

   // Checks in the link domain.
   default clocking link_cb @(posedge scl_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_addr_ack_drive: assert property (
      (state_reg == smbr_pkg::ST_ADDR_ACK) |-> sda_oe_reg)
      else $error("Own address was not acknowledged.");

   chk_rx_ack_drive: assert property (
      (state_reg == smbr_pkg::ST_RX_ACK) |-> sda_oe_reg)
      else $error("Written byte was not acknowledged.");

   chk_tx_bit_out: assert property (
      (state_reg == smbr_pkg::ST_TX) |-> (sda_oe_reg == !shift_reg[7]))
      else $error("Transmitted bit differs from shifter.");

   chk_blk_count_first: assert property (
      (ce_s2 && start_tog_reg == start_ack_reg && load_tx && blk_reg)
      |=> (shift_reg == $past(len_reg)) && !blk_reg)
      else $error("Block read did not start with the count byte.");

   chk_cmd_sets_blk: assert property (
      (ce_s2 && start_tog_reg == start_ack_reg && state_reg == smbr_pkg::ST_RX
       && bit_reg == smbr_pkg::BIT_LAST && idx_reg == smbr_pkg::IDX_CMD
       && rx_byte == smbr_pkg::CMD_BLOCK_READ) |=> blk_reg && sda_oe_reg)
      else $error("Block command was not taken.");

   chk_ptr_step: assert property (
      (ce_s2 && load_tx && !blk_reg && ptr_reg != smbr_pkg::PTR_TOP)
      |=> (ptr_reg == $past(ptr_reg) + 8'h01))
      else $error("Pointer did not advance after a data byte.");

   chk_ptr_no_wrap: assert property (
      (ce_s2 && load_tx && !blk_reg && ptr_reg == smbr_pkg::PTR_TOP)
      |=> (ptr_reg == smbr_pkg::PTR_TOP))
      else $error("Pointer wrapped past the top address.");

   chk_ack_more: assert property (
      (ce_s2 && start_tog_reg == start_ack_reg && state_reg == smbr_pkg::ST_TX_ACK
       && !sda_i) |=> (state_reg == smbr_pkg::ST_TX) [*8] ##1
      (state_reg == smbr_pkg::ST_TX_ACK))
      else $error("Acknowledged byte was not followed by another.");

   chk_nack_release: assert property (
      (ce_s2 && state_reg == smbr_pkg::ST_TX_ACK && sda_i) |=> !sda_oe_reg)
      else $error("Data line held after master NACK.");

   cov_block_count: cover property (load_tx && blk_reg);
   cov_nack_end: cover property (state_reg == smbr_pkg::ST_TX_ACK && sda_i);
   cov_word_read: cover property (
      (state_reg == smbr_pkg::ST_TX_ACK && !sda_i) ##9
      (state_reg == smbr_pkg::ST_TX_ACK && sda_i));

endmodule

/* sim/smbr_host_model.sv */
/*
 * Behavioural bus master that drives the read engine's link.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/100ps

module smbr_host_model (
   output logic scl_o,
   output logic sda_oe_o,
   input wire logic sda_i
);
   // The clock stands high and the line is released between frames.
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   // One idle clock pulse with the data line high.
   task automatic pulse();
      #24 scl_o = 1'b0;
      #24 scl_o = 1'b1;
   endtask

   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      #12 sda_oe_o = 1'b0;
      #12 scl_o = 1'b1;
      #12 sda_oe_o = 1'b1;
      #12 scl_o = 1'b0;
   endtask

   task automatic stop();
      #12 sda_oe_o = 1'b1;
      #12 scl_o = 1'b1;
      #12 sda_oe_o = 1'b0;
      #12;
   endtask

   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #12 sda_oe_o = ~b[i];
         #12 scl_o = 1'b1;
         #24 scl_o = 1'b0;
      end
      #12 sda_oe_o = 1'b0;
      #12 scl_o = 1'b1;
      ack = ~sda_i;
      #24 scl_o = 1'b0;
   endtask

   task automatic recv(input logic ack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #12 sda_oe_o = 1'b0;
         #12 scl_o = 1'b1;
         b[i] = sda_i;
         #24 scl_o = 1'b0;
      end
      #12 sda_oe_o = ack;
      #12 scl_o = 1'b1;
      #24 scl_o = 1'b0;
   endtask
endmodule

/* sim/smbr_read_engine_test.sv */
/*
 * Self-checking bench of the read engine with a behavioural master.
 * Assumes the engine and host model files are compiled before it.
 */
`timescale 1ns/100ps

module smbr_read_engine_test;
   localparam logic [6:0] ADDR = 7'h2c;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr = 1'b0;
   logic [7:0] waddr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic dut_oe, dut_sda, host_oe, scl, sda;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;

   // Open-drain wire with a pull-up.
   assign sda = ~(dut_oe | host_oe);
   always #5 clk = ~clk;

   smbr_read_engine #(.IMPL_DEPTH(250)) smbr_read_engine_inst (
      .clk_i(clk), .sys_rst_i(sys_rst), .ce_i(1'b1), .scl_clk_i(scl), .sda_i(sda),
      .slv_addr_i(ADDR), .reg_wr_i(reg_wr), .reg_waddr_i(waddr),
      .reg_wdata_i(wdata), .sda_o(dut_sda), .sda_oe_o(dut_oe));
   smbr_host_model smbr_host_model_inst (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));

   // Expected register content; unimplemented places read zero.
   function automatic logic [7:0] ex(input logic [7:0] a);
      return (a < 8'hfa) ? (a ^ 8'h5a) : 8'h00;
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [7:0] b);
      logic a;
      smbr_host_model_inst.send(b, a);
      chk({7'h00, a}, 8'h01);
   endtask

   task automatic rd(input logic [7:0] e, input logic last);
      logic [7:0] d;
      smbr_host_model_inst.recv(~last, d);
      chk(d, e);
   endtask

   // Start, own write address, then one command or register byte.
   task automatic open(input logic [7:0] c);
      smbr_host_model_inst.start();
      wr({ADDR, 1'b0});
      wr(c);
   endtask

   task automatic read_addr();
      smbr_host_model_inst.start();
      wr({ADDR, 1'b1});
   endtask

   // Line must be free after the closing not-acknowledge.
   task automatic release_stop();
      #6 chk({7'h00, dut_oe}, 8'h00);
      chk({7'h00, dut_sda}, 8'h00);
      smbr_host_model_inst.stop();
   endtask

   task automatic t_byte();
      open(8'h10);
      read_addr();
      rd(ex(8'h10), 1'b1);
      release_stop();
      $display("byte read done");
   endtask

   task automatic t_word();
      open(8'hbf);
      read_addr();
      rd(ex(8'hbf), 1'b0);
      rd(ex(8'hc0), 1'b1);
      release_stop();
      $display("word read done");
   endtask

   task automatic t_block();
      logic [7:0] a;
      open(8'hf1);
      wr(8'h02);
      wr(8'hf8);
      wr(8'h02);
      read_addr();
      rd(8'h02, 1'b0);
      for (int i = 0; i < 10; i++) begin
         a = (i < 8) ? (8'hf8 + i[7:0]) : 8'hff;
         rd(ex(a), i == 9);
      end
      release_stop();
      $display("block read done");
   endtask

   task automatic t_split();
      logic a;
      open(8'hf1);
      wr(8'h02);
      wr(8'h20);
      wr(8'h03);
      smbr_host_model_inst.stop();
      open(8'hf1);
      read_addr();
      rd(8'h03, 1'b0);
      for (int i = 0; i < 3; i++) begin
         rd(ex(8'h20 + i[7:0]), i == 2);
      end
      release_stop();
      read_addr();
      rd(ex(8'h23), 1'b1);
      release_stop();
      smbr_host_model_inst.start();
      smbr_host_model_inst.send({ADDR ^ 7'h01, 1'b0}, a);
      chk({7'h00, a}, 8'h00);
      smbr_host_model_inst.stop();
      $display("split read done");
   endtask

   // Cut a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 256; a++) begin
         @(posedge clk);
         reg_wr <= 1'b1;
         waddr <= a[7:0];
         wdata <= a[7:0] ^ 8'h5a;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
      smbr_host_model_inst.pulse();
      smbr_host_model_inst.pulse();
      t_byte();
      t_word();
      t_block();
      t_split();
      give_verdict();
   end
endmodule
